// ==== hw/bitop_decoder.sv ====
// bit clear/set/toggle, bit-test skips, watchdog clear, complement and the
// register-to-register move of an 8-bit core, with fetch and four-phase timing
// assumes a combinational program memory answering prog_addr in the same cycle
// and a data memory answering a read strobe with data in the following cycle
//
// The plain strobed port and the register addresses were decided locally.
`timescale 1ns/1ps

module bitop_decoder #(
  parameter int PC_W = 14,
  parameter logic [bitop_pkg::BANK_W-1:0] ACCESS_HI_BANK = 6'h3f
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // program memory
  output logic [PC_W-1:0] prog_addr,
  input wire logic [bitop_pkg::WORD_W-1:0] prog_rdata,
  // data memory
  output bitop_pkg::dmem_req_t dmem_req,
  input wire logic [bitop_pkg::DATA_W-1:0] dmem_rdata,
  // indexed literal offset base
  input wire logic [bitop_pkg::ADDR_W-1:0] index_base,
  // watchdog
  output logic wdt_clear,
  // software register port
  input wire logic [bitop_pkg::REG_ADDR_W-1:0] reg_addr,
  input wire logic [bitop_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [bitop_pkg::DATA_W-1:0] reg_rdata
);
  import bitop_pkg::*;

  phase_t phase;
  logic [WORD_W-1:0] ir;
  logic [PC_W-1:0] pc;
  logic move_pending;
  logic [DATA_W-1:0] move_data;
  logic [DATA_W-1:0] result;
  logic result_neg;
  logic result_zero;
  logic skip_taken;
  logic [1:0] ctrl;
  logic [BANK_W-1:0] bank_select_reg;
  logic [DATA_W-1:0] working_reg;
  logic neg_flag;
  logic zero_flag;
  logic timeout_flag;
  logic power_down_flag;

  op_t op;
  logic [2:0] bit_sel;
  logic [DATA_W-1:0] bit_mask;
  logic [DATA_W-1:0] operand;
  logic dest_file;
  logic access_sel;
  logic [ADDR_W-1:0] eff_addr;
  logic [ADDR_W-1:0] move_addr;
  logic needs_read;
  logic writes_file;
  logic run;
  logic ext_enable;

  assign run = ctrl[CTRL_RUN_BIT];
  assign ext_enable = ctrl[CTRL_EXT_BIT];
  assign prog_addr = pc;

  // instruction decode; unrecognised words, including fillers with no move pending, run as nop
  always_comb begin
    op = OP_NOP;
    if (ir[WORD_W-1:F_OPC4_LSB] == OPC_BIT_CLEAR) begin
      op = OP_BIT_CLEAR;
    end else if (ir[WORD_W-1:F_OPC4_LSB] == OPC_BIT_SET) begin
      op = OP_BIT_SET;
    end else if (ir[WORD_W-1:F_OPC4_LSB] == OPC_BIT_TOGGLE) begin
      op = OP_BIT_TOGGLE;
    end else if (ir[WORD_W-1:F_OPC4_LSB] == OPC_SKIP_ZERO) begin
      op = OP_SKIP_ZERO;
    end else if (ir[WORD_W-1:F_OPC4_LSB] == OPC_SKIP_ONE) begin
      op = OP_SKIP_ONE;
    end else if (ir[WORD_W-1:F_OPC6_LSB] == OPC_COMPLEMENT) begin
      op = OP_COMPLEMENT;
    end else if (ir == WORD_WDT_CLEAR) begin
      op = OP_WDT_CLEAR;
    end else if (ir[WORD_W-1:F_OPC4_LSB] == OPC_MOVE_FIRST) begin
      op = OP_MOVE_SRC;
    end else if (ir[WORD_W-1:F_OPC4_LSB] == OPC_FILLER && move_pending) begin
      // a filler carries data only when its first word fetched it
      op = OP_MOVE_DST;
    end
  end

  // operand fields
  assign bit_sel = ir[F_BIT_LSB +: 3];
  assign bit_mask = 8'h01 << bit_sel;
  assign operand = ir[DATA_W-1:0];
  assign dest_file = ir[F_DEST_BIT];
  assign access_sel = ir[F_ACCESS_BIT];
  assign move_addr = {MOVE_BANK_FORCE, ir[F_MOVE_LSB +: MOVE_ADDR_W]};

  // effective data address of the single-word operand;
  // indexed offsets win over the low access bank while the extended set is on
  always_comb begin
    if (access_sel) begin
      eff_addr = {bank_select_reg, operand};
    end else if (ext_enable && operand <= INDEXED_LAST) begin
      eff_addr = ADDR_W'(index_base + {6'h00, operand});
    end else if (operand <= INDEXED_LAST) begin
      eff_addr = {6'h00, operand};
    end else begin
      eff_addr = {ACCESS_HI_BANK, operand};
    end
  end

  // which operations touch the file
  always_comb begin
    needs_read = 1'b0;
    writes_file = 1'b0;
    case (op)
      OP_BIT_CLEAR, OP_BIT_SET, OP_BIT_TOGGLE: begin
        needs_read = 1'b1;
        writes_file = 1'b1;
      end
      OP_SKIP_ZERO, OP_SKIP_ONE, OP_MOVE_SRC: begin
        needs_read = 1'b1;
      end
      OP_COMPLEMENT: begin
        needs_read = 1'b1;
        writes_file = dest_file;
      end
      OP_MOVE_DST: begin
        writes_file = 1'b1;
      end
      default: begin
        needs_read = 1'b0;
      end
    endcase
  end

  // phase sequencer; a stopped core parks at decode between cycles
  // clearing run mid-cycle lets the instruction in flight finish first
  always_ff @(posedge clk) begin
    if (reset) begin
      phase <= PH_DECODE;
    end else begin
      case (phase)
        PH_DECODE: begin
          if (run) begin
            phase <= PH_READ;
          end
        end
        PH_READ: phase <= PH_PROCESS;
        PH_PROCESS: phase <= PH_WRITE;
        PH_WRITE: phase <= PH_DECODE;
        default: phase <= PH_DECODE;
      endcase
    end
  end

  // data memory strobes: read through the read phase, write through the write phase
  // the address is registered at decode so it stands still until the write
  always_ff @(posedge clk) begin
    if (reset) begin
      dmem_req <= '0;
    end else begin
      dmem_req.rd <= 1'b0;
      dmem_req.wr <= 1'b0;
      if (phase == PH_DECODE && run) begin
        dmem_req.addr <= (op == OP_MOVE_SRC || op == OP_MOVE_DST) ? move_addr : eff_addr;
        dmem_req.rd <= needs_read;
      end else if (phase == PH_PROCESS && writes_file) begin
        dmem_req.wr <= 1'b1;
        dmem_req.wdata <= next_result();
      end
    end
  end

  // data processing on the source byte, ready during the process phase
  function automatic logic [DATA_W-1:0] next_result();
    logic [DATA_W-1:0] value;
    value = dmem_rdata;
    case (op)
      OP_BIT_CLEAR: value = dmem_rdata & ~bit_mask;
      OP_BIT_SET: value = dmem_rdata | bit_mask;
      OP_BIT_TOGGLE: value = dmem_rdata ^ bit_mask;
      OP_COMPLEMENT: value = ~dmem_rdata;
      OP_MOVE_DST: value = move_data;
      default: value = dmem_rdata;
    endcase
    return value;
  endfunction

  // latch result and flag candidates at the process phase
  always_ff @(posedge clk) begin
    if (reset) begin
      result <= '0;
      result_neg <= 1'b0;
      result_zero <= 1'b0;
    end else if (phase == PH_PROCESS) begin
      result <= next_result();
      result_neg <= next_result() >> (DATA_W - 1) != 8'h00;
      result_zero <= next_result() == 8'h00;
    end
  end

  // skip decision, held from the process phase into the write-phase fetch;
  // the nop cycle that follows clears it again at its own process phase
  always_ff @(posedge clk) begin
    if (reset) begin
      skip_taken <= 1'b0;
    end else if (phase == PH_PROCESS) begin
      skip_taken <= (op == OP_SKIP_ZERO && (dmem_rdata & bit_mask) == 8'h00)
        || (op == OP_SKIP_ONE && (dmem_rdata & bit_mask) != 8'h00);
    end
  end

  // source byte of a move, kept until its filler word writes it out
  always_ff @(posedge clk) begin
    if (reset) begin
      move_data <= '0;
    end else if (phase == PH_PROCESS && op == OP_MOVE_SRC) begin
      move_data <= dmem_rdata;
    end
  end

  // watchdog clear pulse stands for the write phase only
  always_ff @(posedge clk) begin
    if (reset) begin
      wdt_clear <= 1'b0;
    end else begin
      wdt_clear <= phase == PH_PROCESS && op == OP_WDT_CLEAR;
    end
  end

  // program counter: one step per instruction cycle, skipped words included
  always_ff @(posedge clk) begin
    if (reset) begin
      pc <= '0;
    end else if (phase == PH_WRITE) begin
      pc <= PC_W'(pc + 1'b1);
    end
  end

  // marks the next word as the filler of a move whose first word ran;
  // a skipped first word leaves it low, so its filler runs as a second nop
  always_ff @(posedge clk) begin
    if (reset) begin
      move_pending <= 1'b0;
    end else if (phase == PH_WRITE) begin
      move_pending <= op == OP_MOVE_SRC && !skip_taken;
    end
  end

  // fetch: a taken skip drops the prefetched word and runs a nop in its slot
  always_ff @(posedge clk) begin
    if (reset) begin
      ir <= WORD_NOP;
    end else if (phase == PH_WRITE) begin
      if (skip_taken) begin
        ir <= WORD_NOP;
      end else begin
        ir <= prog_rdata;
      end
    end
  end

  // control bits: run and extended-set enable, software-owned
  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl <= CTRL_RESET;
    end else if (reg_wr && reg_addr == REG_CTRL) begin
      ctrl <= reg_wdata[1:0];
    end
  end

  // bank select is software-owned; the core only reads it
  always_ff @(posedge clk) begin
    if (reset) begin
      bank_select_reg <= '0;
    end else if (reg_wr && reg_addr == REG_BANK) begin
      bank_select_reg <= reg_wdata[BANK_W-1:0];
    end
  end

  // working register: the core's write wins over a software write
  always_ff @(posedge clk) begin
    if (reset) begin
      working_reg <= '0;
    end else if (phase == PH_WRITE && op == OP_COMPLEMENT && !dest_file) begin
      working_reg <= result;
    end else if (reg_wr && reg_addr == REG_WORK) begin
      working_reg <= reg_wdata;
    end
  end

  // status flags; hardware sets beat a software write in the same cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      {timeout_flag, power_down_flag, zero_flag, neg_flag} <= STATUS_RESET;
    end else begin
      if (reg_wr && reg_addr == REG_STATUS) begin
        neg_flag <= reg_wdata[STAT_NEG_BIT];
        zero_flag <= reg_wdata[STAT_ZERO_BIT];
        power_down_flag <= reg_wdata[STAT_PD_BIT];
        timeout_flag <= reg_wdata[STAT_TO_BIT];
      end
      if (phase == PH_WRITE && op == OP_COMPLEMENT) begin
        neg_flag <= result_neg;
        zero_flag <= result_zero;
      end
      if (phase == PH_WRITE && op == OP_WDT_CLEAR) begin
        timeout_flag <= 1'b1;
        power_down_flag <= 1'b1;
      end
    end
  end

  // register read port, data in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (reset) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      case (reg_addr)
        REG_CTRL: reg_rdata <= {6'h00, ctrl};
        REG_BANK: reg_rdata <= {2'h0, bank_select_reg};
        REG_WORK: reg_rdata <= working_reg;
        REG_STATUS: reg_rdata <= {4'h0, timeout_flag, power_down_flag, zero_flag, neg_flag};
        REG_PC_LO: reg_rdata <= pc[DATA_W-1:0];
        REG_PC_HI: reg_rdata <= DATA_W'(pc >> DATA_W);
        default: reg_rdata <= '0;
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end

endmodule // bitop_decoder

// ==== hw/bitop_pkg.sv ====
// constants, types and encodings shared by the bit-op / complement decoder
// assumes a 16-bit program word, 8-bit data path and a 14-bit data address
package bitop_pkg;

  // widths
  localparam int DATA_W = 8;
  localparam int ADDR_W = 14;
  localparam int WORD_W = 16;
  localparam int BANK_W = 6;
  localparam int REG_ADDR_W = 3;

  // opcode fields: upper nibble, upper six bits, whole words
  localparam logic [3:0] OPC_BIT_CLEAR = 4'h9;
  localparam logic [3:0] OPC_BIT_SET = 4'h8;
  localparam logic [3:0] OPC_BIT_TOGGLE = 4'h7;
  localparam logic [3:0] OPC_SKIP_ZERO = 4'hb;
  localparam logic [3:0] OPC_SKIP_ONE = 4'ha;
  localparam logic [3:0] OPC_MOVE_FIRST = 4'hc;
  localparam logic [3:0] OPC_FILLER = 4'hf;
  localparam logic [5:0] OPC_COMPLEMENT = 6'h07;
  localparam logic [15:0] WORD_WDT_CLEAR = 16'h0004;
  localparam logic [15:0] WORD_NOP = 16'h0000;

  // instruction field positions
  localparam int F_OPC4_LSB = 12;
  localparam int F_OPC6_LSB = 10;
  localparam int F_BIT_LSB = 9;
  localparam int F_DEST_BIT = 9;
  localparam int F_ACCESS_BIT = 8;
  localparam int F_MOVE_LSB = 0;
  localparam int MOVE_ADDR_W = 12;

  // move confines bank select to the lower 4k: top two bank bits forced low
  localparam logic [1:0] MOVE_BANK_FORCE = 2'h0;
  // highest operand treated as an indexed literal offset (95)
  localparam logic [7:0] INDEXED_LAST = 8'h5f;

  // software register offsets
  localparam logic [2:0] REG_CTRL = 3'h0;
  localparam logic [2:0] REG_BANK = 3'h1;
  localparam logic [2:0] REG_WORK = 3'h2;
  localparam logic [2:0] REG_STATUS = 3'h3;
  localparam logic [2:0] REG_PC_LO = 3'h4;
  localparam logic [2:0] REG_PC_HI = 3'h5;

  // bit positions in control and status
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_EXT_BIT = 1;
  localparam int STAT_NEG_BIT = 0;
  localparam int STAT_ZERO_BIT = 1;
  localparam int STAT_PD_BIT = 2;
  localparam int STAT_TO_BIT = 3;

  // reset values
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam logic [3:0] STATUS_RESET = 4'hc;

  // four clock phases per instruction cycle
  typedef enum logic [1:0] {
    PH_DECODE  = 2'b00,
    PH_READ    = 2'b01,
    PH_PROCESS = 2'b10,
    PH_WRITE   = 2'b11
  } phase_t;

  typedef enum logic [3:0] {
    OP_NOP        = 4'b0000,
    OP_BIT_CLEAR  = 4'b0001,
    OP_BIT_SET    = 4'b0010,
    OP_BIT_TOGGLE = 4'b0011,
    OP_SKIP_ZERO  = 4'b0100,
    OP_SKIP_ONE   = 4'b0101,
    OP_COMPLEMENT = 4'b0110,
    OP_WDT_CLEAR  = 4'b0111,
    OP_MOVE_SRC   = 4'b1000,
    OP_MOVE_DST   = 4'b1001
  } op_t;

  // data memory request, one bundle toward the file registers
  typedef struct packed {
    logic rd;
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } dmem_req_t;

endpackage

// ==== tb/bitop_checker.sv ====
// port checker for the bit-op / complement decoder
// assumes only the top module's ports; bound at the foot of this file
`timescale 1ns/1ps
module bitop_checker
  import bitop_pkg::*;
#(
  parameter int PC_W = 14
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // observed outputs
  input wire logic [PC_W-1:0] prog_addr,
  input wire bitop_pkg::dmem_req_t dmem_req,
  input wire logic wdt_clear
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // one read per four-clock instruction cycle
  rd_spacing_a:
    assert property (dmem_req.rd |=> !dmem_req.rd [*3]) else $error("reads too close");
  wr_addr_a:
    assert property (dmem_req.wr |-> dmem_req.addr == $past(dmem_req.addr, 2))
      else $error("write address moved");
  addr_hold_a:
    assert property (dmem_req.rd |=> $stable(dmem_req.addr) [*2]) else $error("address moved");
  strobe_excl_a:
    assert property (dmem_req.wr |-> !dmem_req.rd && !wdt_clear) else $error("strobes overlap");
  wdt_pulse_a:
    assert property (wdt_clear |=> !wdt_clear [*3]) else $error("watchdog pulse too long");
  wdt_nomem_a:
    assert property (wdt_clear |-> !$past(dmem_req.rd, 2)) else $error("watchdog clear read");
  wdt_adv_a:
    assert property (wdt_clear |=> $changed(prog_addr)) else $error("watchdog clear not 1 cycle");
  pc_step_a:
    assert property ($changed(prog_addr) |=> $stable(prog_addr) [*3]) else $error("pc too fast");
  wr_adv_a:
    assert property (dmem_req.wr |=> prog_addr == $past(prog_addr) + 1'b1)
      else $error("bit op not one cycle");

  // main scenarios reached
  cover property (wdt_clear);
  cover property (dmem_req.wr);
  cover property (dmem_req.rd ##2 !dmem_req.wr);
endmodule // bitop_checker

bind bitop_decoder bitop_checker #(.PC_W(PC_W)) chk_u (
  .clk(clk),
  .reset(reset),
  .prog_addr(prog_addr),
  .dmem_req(dmem_req),
  .wdt_clear(wdt_clear)
);

// ==== tb/bitop_decoder_bench.sv ====
// testbench for the bit-op decoder: register port, then one short program
// assumes program and data memory are modelled here, as the design expects
`timescale 1ns/1ps
module bitop_decoder_bench;
  import bitop_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [13:0] prog_addr;
  logic [15:0] prog_rdata;
  dmem_req_t dmem_req;
  logic [7:0] dmem_rdata = 8'h00;
  logic wdt_clear;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic [15:0] prog [0:255];
  logic [7:0] dmem [0:16383];
  int failures = 0;
  int checks = 0;
  int cyc = 0;
  int wdt_at[$];

  bitop_decoder dut_u (
    .clk(clk), .reset(reset), .prog_addr(prog_addr), .prog_rdata(prog_rdata),
    .dmem_req(dmem_req), .dmem_rdata(dmem_rdata), .index_base(14'h0200),
    .wdt_clear(wdt_clear), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata)
  );

  always #5 clk = ~clk;
  // program memory answers in the same cycle
  assign prog_rdata = prog[prog_addr[7:0]];
  // data memory; idle read lines toggle so stale data cannot pass
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (wdt_clear) wdt_at.push_back(cyc);
    dmem_rdata <= dmem_req.rd ? dmem[dmem_req.addr] : ~dmem_rdata;
    if (dmem_req.wr) dmem[dmem_req.addr] <= dmem_req.wdata;
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string msg);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic reg_write(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // data stand only in the cycle after the strobe
  task automatic reg_read(input logic [2:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    check(reg_rdata, exp, "register read");
  endtask

  task automatic finish_test;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // reset values, unmapped and read-only places, core parked
  task automatic test_regs;
    reg_read(REG_CTRL, 8'h00);
    reg_read(REG_STATUS, 8'h0c);
    reg_read(3'h6, 8'h00);
    reg_write(REG_PC_LO, 8'h55);
    reg_read(REG_PC_LO, 8'h00);
    reg_read(REG_PC_HI, 8'h00);
    check(prog_addr[7:0], 8'h00, "pc parked");
    reg_write(REG_BANK, 8'h01);
    reg_read(REG_BANK, 8'h01);
    reg_write(REG_WORK, 8'h5a);
    reg_read(REG_WORK, 8'h5a);
    reg_write(REG_STATUS, 8'h00);
    reg_read(REG_STATUS, 8'h00);
  endtask

  // bit ops, skips over one- and two-word words, move, complement, watchdog marks
  task automatic test_program;
    logic [15:0] code [21] = '{16'h8720, 16'h9010, 16'h7e70, 16'h0004, 16'hb120,
      16'ha120, 16'hc120, 16'hf055, 16'h0004, 16'hb320, 16'h9e10, 16'hf044,
      16'h0004, 16'hc120, 16'hf3a5, 16'h1d20, 16'h1e10, 16'h0004, 16'h0000,
      16'h8430, 16'h0004};
    for (int i = 0; i < 21; i++) prog[i] = code[i];
    dmem[14'h0120] = 8'h81;
    dmem[14'h0210] = 8'hff;
    dmem[14'h0010] = 8'hff;
    dmem[14'h3f70] = 8'h0f;
    reg_write(REG_CTRL, 8'h03);
    for (int i = 0; i < 400 && wdt_at.size() < 4; i++) @(posedge clk);
    // extended set off before the plain access-bank word reaches decode
    reg_write(REG_CTRL, 8'h01);
    for (int i = 0; i < 100 && wdt_at.size() < 5; i++) @(posedge clk);
    reg_write(REG_CTRL, 8'h02);
    if (wdt_at.size() < 5) begin
      failures++;
      $display("CHECK FAILED at %0t: watchdog clear missing", $time);
    end else begin
      check(8'(wdt_at[1] - wdt_at[0]), 8'h14, "skip over move");
      check(8'(wdt_at[2] - wdt_at[1]), 8'h10, "skip one word");
      check(8'(wdt_at[3] - wdt_at[2]), 8'h14, "move and complement");
      check(8'(wdt_at[4] - wdt_at[3]), 8'h0c, "nop and plain set");
      check(dmem[14'h0030], 8'h04, "access low plain set");
      check(dmem[14'h0120], 8'h89, "bit set banked");
      check(dmem[14'h3f70], 8'h8f, "toggle access high");
      check(dmem[14'h0210], 8'h01, "indexed clear, skipped, complemented");
      check(dmem[14'h0010], 8'hff, "access low untouched");
      check(dmem[14'h0055], 8'h00, "skipped move");
      check(dmem[14'h03a5], 8'h89, "move result");
      reg_read(REG_WORK, 8'h76);
      reg_read(REG_STATUS, 8'h0c);
    end
  endtask

  // main sequence
  initial begin
    for (int i = 0; i < 256; i++) prog[i] = 16'h0000;
    for (int i = 0; i < 16384; i++) dmem[i] = 8'h00;
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    test_regs();
    test_program();
    finish_test();
  end
endmodule // bitop_decoder_bench
